// *** rtl/dsr_top.sv ***
/*
 * serial frame decoder, readback modes and monitor converter control.
 * assumes MON_RESULT_IN settles within the conversion time, and that
 * outside registers hold the indices this file does not.
 */
// Operation
// [RULE1] input select is config bits 4:0
// [RULE2] unlisted node codes are reserved
// [RULE3] config write, bits 10:8=100 7:5=000, starts one conversion
// [RULE4] finished conversion puts result in status
// [RULE5] status holds last result and its select code
// [RULE6] no frame while busy: next status has new result
// [RULE7] frame while busy: old result, busy set
// [RULE8] start commands while busy are dropped
// [RULE9] reserved index access flags invalid access
// [RULE10] host writes reserved fields as defaults
// [RULE11] bit 23 must invert bit 22
// [RULE12] bits 22:21 must match address pins
// [RULE13] bits 20:16 register, bits 15:0 data
// [RULE14] crc on after reset: only 32-bit frames
// [RULE15] crc off: 24 bits, or 32 with last byte ignored
// [RULE16] readback select has a four-way mode field
// [RULE17] two-stage: selected register goes out next frame
// [RULE18] no-op is all-zero data to index zero
// [RULE19] new select in second frame answers next
// [RULE20] answer is 10, fault status, index, 16 data bits
// [RULE21] autostatus sends status every frame
// [RULE22] status: 10, fault, diag, wdt, busy, code, result
// [RULE23] bad slip, crc or length: no update, flag set
// [RULE24] conversion takes fixed cycles, busy throughout
module dsr_top #(
    parameter int CONV_CNT = dsr_pkg::CONV_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        SCLK,
    input  wire logic        SYNC_N,
    input  wire logic        SDI,
    output logic             SDO,
    output logic             SDO_OE_N,
    input  wire logic        DEVICE_ADDR_HIGH,
    input  wire logic        DEVICE_ADDR_LOW,
    input  wire logic        FAULT_N_IN,
    input  wire logic        ANALOG_DIAG_SUMMARY,
    input  wire logic        WATCHDOG_FLAG,
    input  wire logic        DIGITAL_DIAG_EXT,
    output logic [4:0]       MON_INPUT_SELECT,
    output logic             MON_CONVERT_START,
    output logic             MON_CONVERT_BUSY,
    input  wire logic [11:0] MON_RESULT_IN,
    output logic             EXT_WR_STROBE,
    output logic [4:0]       EXT_WR_ADDR,
    output logic [15:0]      EXT_WR_DATA,
    output logic [4:0]       EXT_RD_ADDR,
    input  wire logic [15:0] EXT_RD_DATA
);

    typedef struct packed {
        logic                       sync_a;
        logic                       sync_b;
        logic                       sync_c;
        logic                       adh_a;
        logic                       adh_b;
        logic                       adl_a;
        logic                       adl_b;
        logic                       flt_a;
        logic                       flt_b;
        logic [15:0]                diag_cfg;
        logic [15:0]                mon_cfg;
        logic [15:0]                rb_sel;
        logic [dsr_pkg::ERR_W-1:0]  err;
        dsr_pkg::dsr_conv_e         conv_state;
        logic [15:0]                conv_cnt;
        logic [4:0]                 conv_code;
        logic                       conv_start;
        logic [4:0]                 res_code;
        logic [11:0]                result;
        logic                       wr_strobe;
        logic [4:0]                 wr_addr;
        logic [15:0]                wr_data;
        logic                       echo_phase;
        logic [23:0]                last_frame;
        logic                       last_valid;
        logic [31:0]                tx_word;
        logic                       tx_en;
    } dsr_top_s;

    dsr_top_s   top_reg;
    dsr_top_s   top_next;
    logic [31:0] rx_word;
    logic [5:0]  rx_count;

    // link side, host clocked
    dsr_link #(
        .CNT_W (6)
    ) u_link (
        .SCLK     (SCLK),
        .SYNC_N   (SYNC_N),
        .SDI      (SDI),
        .TX_WORD  (top_reg.tx_word),
        .TX_EN    (top_reg.tx_en),
        .SDO      (SDO),
        .SDO_OE_N (SDO_OE_N),
        .RX_WORD  (rx_word),
        .RX_COUNT (rx_count)
    );

    // decode terms, valid at frame end
    logic        frame_end;
    logic        crc_en;
    logic        len_long;
    logic        len_short;
    logic [23:0] frame;
    logic        len_ok;
    logic        slip_ok;
    logic        crc_ok;
    logic        good;
    logic        match;
    logic [4:0]  f_addr;
    logic [15:0] f_data;
    logic        acted;

    assign frame_end = top_reg.sync_b & ~top_reg.sync_c;
    assign crc_en    = top_reg.diag_cfg[dsr_pkg::CRC_EN_BIT];
    assign len_long  = (rx_count == dsr_pkg::LONG_LEN);
    assign len_short = (rx_count == dsr_pkg::SHORT_LEN);
    assign frame     = len_long ? rx_word[31:8] : rx_word[23:0];      // RULE15
    assign len_ok    = crc_en ? len_long : (len_long | len_short); // RULE14
    assign slip_ok   = frame[23] ^ frame[22];                        // RULE11
    assign crc_ok    = ~crc_en | (dsr_pkg::crc8(frame) == rx_word[7:0]);
    assign good      = frame_end & len_ok & slip_ok & crc_ok;        // RULE23
    assign match     = (frame[22:21] == {top_reg.adh_b, top_reg.adl_b});
    assign f_addr    = frame[20:16];                                 // RULE13
    assign f_data    = frame[15:0];
    assign acted     = good & match;                                 // RULE12

    // status word and readback data
    logic        dig_sum;
    logic        fault_stat;
    logic [23:0] status_word;
    logic [4:0]  rb_addr;
    logic [15:0] rb_data;
    logic [23:0] resp;
    logic        start_cmd;

    assign dig_sum    = (|top_reg.err) | DIGITAL_DIAG_EXT;
    assign fault_stat = ~top_reg.flt_b;
    assign status_word = {dsr_pkg::SYNC_PAT, fault_stat, dig_sum,   // RULE22
                          ANALOG_DIAG_SUMMARY, WATCHDOG_FLAG,
                          top_reg.conv_state == dsr_pkg::CONV_BUSY,
                          top_reg.res_code, top_reg.result};       // RULE5
    assign rb_addr = top_reg.rb_sel[dsr_pkg::RB_ADDR_LSB +: 5];
    assign start_cmd = (f_data[dsr_pkg::TRIG_LSB +: 3] == dsr_pkg::TRIG_CODE)
                    && (f_data[dsr_pkg::GAP_LSB +: 3] == dsr_pkg::GAP_CODE);

    // two-stage read mux
    always_comb begin
        case (rb_addr)
            dsr_pkg::ADDR_NOP:      rb_data = 16'h0000;
            dsr_pkg::ADDR_DIAG_CFG: rb_data = top_reg.diag_cfg;
            dsr_pkg::ADDR_MON_CFG:  rb_data = top_reg.mon_cfg;
            dsr_pkg::ADDR_RB_SEL:   rb_data = top_reg.rb_sel;
            dsr_pkg::ADDR_DIAG_RES: rb_data = {12'h000, top_reg.err};
            dsr_pkg::ADDR_STATUS:   rb_data = status_word[15:0];
            default:                rb_data = EXT_RD_DATA;
        endcase
    end

    // answer by readback mode
    always_comb begin
        case (dsr_pkg::dsr_rb_mode_e'(
                  top_reg.rb_sel[dsr_pkg::RB_MODE_LSB +: 2])) // RULE16
            dsr_pkg::RB_TWO_STAGE: begin
                if (rb_addr == dsr_pkg::ADDR_STATUS) begin
                    resp = status_word;
                end else begin
                    resp = {dsr_pkg::SYNC_PAT, fault_stat,    // RULE20
                            rb_addr, rb_data};                // RULE17
                end
            end
            dsr_pkg::RB_ECHO: begin
                resp = top_reg.echo_phase ? top_reg.last_frame
                                          : status_word;
            end
            default: begin
                resp = status_word;                           // RULE21
            end
        endcase
    end

    // core-clock next state
    always_comb begin
        logic [dsr_pkg::ERR_W-1:0] err_set;
        logic [dsr_pkg::ERR_W-1:0] err_clr;
        logic                      is_shared;
        err_set  = '0;
        err_clr  = '0;
        is_shared = 1'b0;
        top_next = top_reg;

        // two-flop synchronisers
        top_next.sync_a = SYNC_N;
        top_next.sync_b = top_reg.sync_a;
        top_next.sync_c = top_reg.sync_b;
        top_next.adh_a  = DEVICE_ADDR_HIGH;
        top_next.adh_b  = top_reg.adh_a;
        top_next.adl_a  = DEVICE_ADDR_LOW;
        top_next.adl_b  = top_reg.adl_a;
        top_next.flt_a  = FAULT_N_IN;
        top_next.flt_b  = top_reg.flt_a;

        top_next.wr_strobe  = 1'b0;
        top_next.conv_start = 1'b0;

        // frame checks, failed frames raise flags, flip echo_phase and clear last_valid
        if (frame_end) begin
            err_set[dsr_pkg::ERR_LEN]  = ~len_ok;                  // RULE23
            err_set[dsr_pkg::ERR_SLIP] = len_ok & ~slip_ok;       // RULE11
            err_set[dsr_pkg::ERR_CRC]  = len_ok & ~crc_ok;        // RULE14
            top_next.echo_phase = ~top_reg.echo_phase;
            top_next.last_valid = acted;
            if (acted) begin
                top_next.last_frame = frame;
            end
        end

        // writes of an accepted, matched frame
        if (acted) begin
            if (dsr_pkg::addr_reserved(f_addr)) begin
                err_set[dsr_pkg::ERR_INVALID] = 1'b1;              // RULE9
            end else begin
                case (f_addr)
                    dsr_pkg::ADDR_NOP: begin
                    end
                    dsr_pkg::ADDR_DIAG_CFG: begin
                        top_next.diag_cfg = f_data;
                    end
                    dsr_pkg::ADDR_MON_CFG: begin
                        if (start_cmd) begin
                            if (top_reg.conv_state == dsr_pkg::CONV_IDLE) begin
                                top_next.mon_cfg    = f_data;      // RULE3
                                top_next.conv_state = dsr_pkg::CONV_BUSY;
                                top_next.conv_cnt   = 16'(CONV_CNT - 1);
                                top_next.conv_code  =
                                    f_data[dsr_pkg::SEL_LSB +: 5]; // RULE1
                                top_next.conv_start = 1'b1;
                            end                                    // RULE8
                        end else begin
                            top_next.mon_cfg = f_data;
                        end
                    end
                    dsr_pkg::ADDR_RB_SEL: begin
                        top_next.rb_sel = f_data;                  // RULE19
                        err_set[dsr_pkg::ERR_INVALID] = dsr_pkg::addr_reserved(
                            f_data[dsr_pkg::RB_ADDR_LSB +: 5]);    // RULE9
                    end
                    dsr_pkg::ADDR_DIAG_RES: begin
                        err_clr = f_data[dsr_pkg::ERR_W-1:0];
                    end
                    dsr_pkg::ADDR_STATUS: begin
                    end
                    default: begin
                        top_next.wr_strobe = 1'b1;
                        top_next.wr_addr   = f_addr;
                        top_next.wr_data   = f_data;
                    end
                endcase
            end
        end

        // write one clears, set wins
        top_next.err = (top_reg.err & ~err_clr) | err_set;

        // conversion timer, busy for the whole interval
        case (top_reg.conv_state)
            dsr_pkg::CONV_IDLE: begin
            end
            dsr_pkg::CONV_BUSY: begin
                if (top_reg.conv_cnt == 16'h0000) begin           // RULE24
                    top_next.conv_state = dsr_pkg::CONV_IDLE;
                    top_next.res_code   = top_reg.conv_code;       // RULE5
                    top_next.result     =
                        dsr_pkg::node_valid(top_reg.conv_code)     // RULE2
                        ? MON_RESULT_IN : 12'h000;                 // RULE4
                end else begin
                    top_next.conv_cnt = top_reg.conv_cnt - 16'h0001;
                end
            end
            default: begin
                top_next.conv_state = dsr_pkg::CONV_IDLE;
            end
        endcase

        // answer tracks state while no frame runs
        is_shared = (top_reg.rb_sel[dsr_pkg::RB_MODE_LSB +: 2]
                     == 2'(dsr_pkg::RB_SHARED));
        if (top_reg.sync_b) begin                            // RULE6
            top_next.tx_en   = ~is_shared | top_reg.last_valid;
            if (crc_en) begin
                top_next.tx_word = {resp, dsr_pkg::crc8(resp)};
            end else begin
                top_next.tx_word = {resp, 8'h00};
            end
        end                                                  // RULE7

        // synchronous reset
        if (!RSTN) begin
            top_next            = '0;
            top_next.sync_a     = 1'b1;
            top_next.sync_b     = 1'b1;
            top_next.sync_c     = 1'b1;
            top_next.flt_a      = 1'b1;
            top_next.flt_b      = 1'b1;
            top_next.diag_cfg   = dsr_pkg::DIAG_CFG_RST;
            top_next.mon_cfg    = dsr_pkg::MON_CFG_RST;
            top_next.rb_sel     = dsr_pkg::RB_SEL_RST;
            top_next.conv_state = dsr_pkg::CONV_IDLE;
            top_next.tx_en      = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        top_reg <= top_next;
    end

    // outputs straight from registers
    assign MON_INPUT_SELECT  = top_reg.mon_cfg[dsr_pkg::SEL_LSB +: 5];
    assign MON_CONVERT_START = top_reg.conv_start;
    assign MON_CONVERT_BUSY  = (top_reg.conv_state == dsr_pkg::CONV_BUSY);
    assign EXT_WR_STROBE     = top_reg.wr_strobe;
    assign EXT_WR_ADDR       = top_reg.wr_addr;
    assign EXT_WR_DATA       = top_reg.wr_data;
    assign EXT_RD_ADDR       = rb_addr;

endmodule : dsr_top

// *** rtl/dsr_pkg.sv ***
/*
 * constants, types and helper functions used by the serial frame
 * decoder; its link shifter uses none of them.
 * assumes a 250 MHz core clock and a host that clocks the link.
 */
package dsr_pkg;

    // core clock and conversion timing
    localparam int REF_CLK_MHZ  = 250;
    localparam int CONV_TIME_NS = 2000;
    localparam int CONV_CYCLES  = (CONV_TIME_NS * REF_CLK_MHZ + 999) / 1000;

    // register indices
    localparam logic [4:0] ADDR_NOP      = 5'h00;
    localparam logic [4:0] ADDR_DIAG_CFG = 5'h10;
    localparam logic [4:0] ADDR_MON_CFG  = 5'h11;
    localparam logic [4:0] ADDR_RB_SEL   = 5'h13;
    localparam logic [4:0] ADDR_DIAG_RES = 5'h14;
    localparam logic [4:0] ADDR_STATUS   = 5'h16;
    localparam logic [4:0] ADDR_LAST     = 5'h1c;

    // reset values
    localparam logic [15:0] DIAG_CFG_RST = 16'h005d;
    localparam logic [15:0] MON_CFG_RST  = 16'h0000;
    localparam logic [15:0] RB_SEL_RST   = 16'h0000;

    // field positions
    localparam int CRC_EN_BIT  = 0;
    localparam int SEL_LSB     = 0;
    localparam int TRIG_LSB    = 8;
    localparam int GAP_LSB     = 5;
    localparam int RB_ADDR_LSB = 0;
    localparam int RB_MODE_LSB = 8;
    localparam logic [2:0] TRIG_CODE = 3'h4;
    localparam logic [2:0] GAP_CODE  = 3'h0;

    // digital diagnostic result flags
    localparam int ERR_CRC     = 0;
    localparam int ERR_SLIP    = 1;
    localparam int ERR_LEN     = 2;
    localparam int ERR_INVALID = 3;
    localparam int ERR_W       = 4;

    // frame layout
    localparam logic [1:0] SYNC_PAT  = 2'h2;
    localparam logic [5:0] LONG_LEN  = 6'h20;
    localparam logic [5:0] SHORT_LEN = 6'h18;
    localparam logic [7:0] CRC_POLY  = 8'h07;

    // monitor input node codes
    localparam logic [4:0] NODE_DIE_TEMP   = 5'h00;
    localparam logic [4:0] NODE_DAC_DAC_REFERENCE_INPUT  = 5'h03;
    localparam logic [4:0] NODE_BANDGAP    = 5'h04;
    localparam logic [4:0] NODE_SENSE_POS  = 5'h0d;
    localparam logic [4:0] NODE_SENSE_NEG  = 5'h0e;
    localparam logic [4:0] NODE_INTERNAL_ANALOG_SUPPLY   = 5'h14;
    localparam logic [4:0] NODE_LOGIC_SUP  = 5'h16;
    localparam logic [4:0] NODE_REF_GND    = 5'h18;
    localparam logic [4:0] NODE_DIG_GND    = 5'h1a;
    localparam logic [4:0] NODE_POS_SUP1   = 5'h1b;
    localparam logic [4:0] NODE_NEG_SUPPLY = 5'h1d;
    localparam logic [4:0] NODE_REF_OUT    = 5'h1f;

    typedef enum logic [1:0] {
        RB_TWO_STAGE,
        RB_AUTOSTATUS,
        RB_SHARED,
        RB_ECHO
    } dsr_rb_mode_e;

    typedef enum logic {
        CONV_IDLE,
        CONV_BUSY
    } dsr_conv_e;

    // true for a code that names a real monitor node
    function automatic logic node_valid(input logic [4:0] c);
        node_valid = (c == NODE_DIE_TEMP) || (c == NODE_DAC_DAC_REFERENCE_INPUT)
            || (c == NODE_BANDGAP) || (c == NODE_SENSE_POS)
            || (c == NODE_SENSE_NEG) || (c == NODE_REF_OUT)
            || ((c >= NODE_INTERNAL_ANALOG_SUPPLY) && (c <= NODE_LOGIC_SUP))
            || ((c >= NODE_REF_GND) && (c <= NODE_NEG_SUPPLY));
    endfunction : node_valid

    // true for a register index that holds nothing
    function automatic logic addr_reserved(input logic [4:0] a);
        addr_reserved = ((a >= 5'h0b) && (a <= 5'h0e))
            || ((a >= 5'h19) && (a <= 5'h1b)) || (a > ADDR_LAST);
    endfunction : addr_reserved

    // msb-first crc over a 24-bit frame body
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            if (c[7] ^ d[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc8 = c;
    endfunction : crc8

endpackage : dsr_pkg

// *** rtl/dsr_link.sv ***
/*
 * link shifter on the host clock: bits in, answer out msb first.
 * assumes TX_WORD is steady while the select is low.
 */
module dsr_link #(
    parameter int CNT_W = 6
) (
    input  wire logic             SCLK,
    input  wire logic             SYNC_N,
    input  wire logic             SDI,
    input  wire logic [31:0]      TX_WORD,
    input  wire logic             TX_EN,
    output logic                  SDO,
    output logic                  SDO_OE_N,
    output logic [31:0]           RX_WORD,
    output logic [CNT_W-1:0]      RX_COUNT
);

    typedef struct packed {
        logic [31:0]      rx;
        logic [31:0]      tx;
        logic [CNT_W-1:0] cnt;
    } dsr_link_s;

    dsr_link_s  link_reg;
    dsr_link_s  link_next;
    logic       fresh_reg;

    // set by the frame select, restarts each frame
    always_ff @(posedge SCLK or posedge SYNC_N) begin
        if (SYNC_N) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    // shift on rising edges, count saturates
    always_comb begin
        link_next = link_reg;
        if (fresh_reg) begin
            link_next.rx  = {31'h0, SDI};
            link_next.cnt = CNT_W'(1);
            link_next.tx  = {TX_WORD[30:0], 1'b0};
        end else begin
            link_next.rx = {link_reg.rx[30:0], SDI};
            link_next.tx = {link_reg.tx[30:0], 1'b0};
            if (link_reg.cnt != {CNT_W{1'b1}}) begin
                link_next.cnt = link_reg.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge SCLK) begin
        link_reg <= link_next;
    end

    // first bit straight from the word
    assign SDO      = fresh_reg ? TX_WORD[31] : link_reg.tx[31];
    assign SDO_OE_N = SYNC_N | ~TX_EN;
    assign RX_WORD  = link_reg.rx;
    assign RX_COUNT = link_reg.cnt;

endmodule : dsr_link

// *** tb/dsr_top_asserts.sv ***
/* port checker: converter timing, outside write port.
   assumes the bind below into dsr_top. */
module dsr_top_checker #(
    parameter int CONV_CNT = 8
) (
    input wire logic       REF_CLK,
    input wire logic       RSTN,
    input wire logic       SYNC_N,
    input wire logic       SDO_OE_N,
    input wire logic [4:0] MON_INPUT_SELECT,
    input wire logic       MON_CONVERT_START,
    input wire logic       MON_CONVERT_BUSY,
    input wire logic       EXT_WR_STROBE,
    input wire logic [4:0] EXT_WR_ADDR
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    int busy_cnt;
    // cycles of the running conversion
    always_ff @(posedge REF_CLK) begin
        busy_cnt <= (RSTN && MON_CONVERT_BUSY) ? busy_cnt + 1 : 0;
    end
    property p_start_busy;
        MON_CONVERT_START |-> ##[0:1] MON_CONVERT_BUSY;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start without busy");
    property p_busy_cause;
        $rose(MON_CONVERT_BUSY) |->
            MON_CONVERT_START || $past(MON_CONVERT_START);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy without start");
    property p_busy_len;
        $fell(MON_CONVERT_BUSY) |-> busy_cnt == CONV_CNT;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    property p_busy_max;
        MON_CONVERT_BUSY |-> busy_cnt < CONV_CNT;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("busy too long");
    property p_no_start_busy;
        MON_CONVERT_START |-> !(MON_CONVERT_BUSY && $past(MON_CONVERT_BUSY));
    endproperty
    a_no_start_busy: assert property (p_no_start_busy)
        else $error("start while busy");
    property p_sel_hold;
        MON_CONVERT_BUSY && $past(MON_CONVERT_BUSY) |->
            $stable(MON_INPUT_SELECT);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("select moved in conversion");
    property p_idle_oe;
        SYNC_N |-> SDO_OE_N;
    endproperty
    a_idle_oe: assert property (p_idle_oe)
        else $error("sdo driven outside frame");
    property p_ext_rsvd;
        EXT_WR_STROBE |-> !(EXT_WR_ADDR inside {[5'h0b:5'h0e],
            [5'h19:5'h1b], 5'h1d, 5'h1e, 5'h1f});
    endproperty
    a_ext_rsvd: assert property (p_ext_rsvd)
        else $error("reserved index written out");
    property p_ext_local;
        EXT_WR_STROBE |-> !(EXT_WR_ADDR inside {5'h00, 5'h10, 5'h11,
            5'h13, 5'h14, 5'h16});
    endproperty
    a_ext_local: assert property (p_ext_local)
        else $error("local index written out");
    property p_ext_hold;
        !EXT_WR_STROBE |-> $stable(EXT_WR_ADDR);
    endproperty
    a_ext_hold: assert property (p_ext_hold)
        else $error("outside address moved");
endmodule : dsr_top_checker

bind dsr_top dsr_top_checker #(.CONV_CNT(CONV_CNT)) dsr_top_checker_inst (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .SYNC_N(SYNC_N), .SDO_OE_N(SDO_OE_N),
    .MON_INPUT_SELECT(MON_INPUT_SELECT),
    .MON_CONVERT_START(MON_CONVERT_START),
    .MON_CONVERT_BUSY(MON_CONVERT_BUSY),
    .EXT_WR_STROBE(EXT_WR_STROBE), .EXT_WR_ADDR(EXT_WR_ADDR));

// *** tb/dsr_host_model.sv ***
/* host model: one frame per call, 6 ns link clock.
   assumes sdo msb first, changing on rising edges. */
module dsr_host_model (
    output logic      sclk,
    output logic      sync_n,
    output logic      sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] MY_ADDR = 2'h2;
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdi = 1'b0;
    end
    // flaw bit0 spoils crc, bit1 the slip bit, bit2 the address
    task automatic send(input logic [4:0] idx, input logic [15:0] d,
            input int n, input logic [2:0] flaw, output logic [31:0] r);
        logic [1:0]  a;
        logic [23:0] b;
        logic [7:0]  c;
        logic [31:0] w;
        a = MY_ADDR ^ {1'b0, flaw[2]};
        b = {~a[1] ^ flaw[1], a, idx, d};
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
        end
        w = {b, (n == 32) ? c ^ {7'h0, flaw[0]} : 8'h00};
        r = 32'h0;
        sync_n = 1'b0;
        #16;
        for (int i = 0; i < n; i++) begin
            sdi = w[31-i];
            r = {r[30:0], sdo};
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
        #3 sync_n = 1'b1;
        sdi = ~sdi; // released line inverts
        #40;
    endtask : send
endmodule : dsr_host_model

// *** tb/testbench.sv ***
/* frame decoder bench.
   assumes host model and checker compiled first. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CC = 100;
    logic        ref_clk, rstn, sclk, sync_n, sdi, sdo, oe_n;
    logic        fault_n, wdt, start, busy, ext_st;
    logic [4:0]  sel, ext_wa, ext_ra;
    logic [15:0] ext_wd;
    logic [11:0] res;
    logic [31:0] rx;
    int          err_count, checked, starts;
    dsr_host_model dsr_host_model_inst (.sclk(sclk), .sync_n(sync_n),
        .sdi(sdi), .sdo(sdo));
    dsr_top #(.CONV_CNT(CC)) dsr_top_inst (.REF_CLK(ref_clk), .RSTN(rstn),
        .SCLK(sclk), .SYNC_N(sync_n), .SDI(sdi), .SDO(sdo), .SDO_OE_N(oe_n),
        .DEVICE_ADDR_HIGH(1'b1), .DEVICE_ADDR_LOW(1'b0),
        .FAULT_N_IN(fault_n), .ANALOG_DIAG_SUMMARY(1'b0),
        .WATCHDOG_FLAG(wdt), .DIGITAL_DIAG_EXT(1'b0),
        .MON_INPUT_SELECT(sel), .MON_CONVERT_START(start),
        .MON_CONVERT_BUSY(busy), .MON_RESULT_IN(res),
        .EXT_WR_STROBE(ext_st), .EXT_WR_ADDR(ext_wa), .EXT_WR_DATA(ext_wd),
        .EXT_RD_ADDR(ext_ra), .EXT_RD_DATA(16'h0000));
    // core clock, 4 ns
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // counts starts
    always @(posedge ref_clk) begin
        if (start === 1'b1) begin
            starts <= starts + 1;
        end
    end
    task automatic final_report();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // answer body of last frame
    task automatic chk_rx(input logic [23:0] exp);
        chk({8'h0, rx[31:8]}, {8'h0, exp});
    endtask : chk_rx
    function automatic logic [23:0] st(logic b, logic [4:0] c,
            logic [11:0] r);
        return {2'h2, ~fault_n, 1'b1, 1'b0, wdt, b, c, r};
    endfunction : st
    task automatic fr(input logic [4:0] i, input logic [15:0] d,
            input int n = 32, input logic [2:0] f = 3'h0);
        @(posedge ref_clk);
        #1;
        dsr_host_model_inst.send(i, d, n, f, rx);
    endtask : fr
    task automatic wait_idle();
        int i;
        for (i = 0; i < 300 && busy !== 1'b0; i++) begin
            @(posedge ref_clk);
        end
        #1;
        if (i == 300) begin
            err_count++;
            final_report();
        end
    endtask : wait_idle
    // bad frames start and write nothing, good one goes out
    task automatic t_reject();
        fr(5'h11, 16'h040d, 24);
        fr(5'h11, 16'h040d, 32, 3'h1);
        fr(5'h11, 16'h040d, 32, 3'h2);
        fr(5'h11, 16'h040d, 32, 3'h4);
        fr(5'h01, 16'h1234);
        fr(5'h0b, 16'h0000);
        chk({starts[15:0], 11'h0, sel}, 32'h0);
        chk({11'h0, ext_wa, ext_wd}, 32'h0001_1234);
        $display("reject done");
    endtask : t_reject
    // autostatus, busy overlap, crc off
    task automatic t_conv();
        res = 12'h5a5;
        fr(5'h13, 16'h0100);
        fr(5'h11, 16'h040d);
        chk_rx(st(1'b0, 5'h00, 12'h000));
        fr(5'h11, 16'h0403);
        chk_rx(st(1'b1, 5'h00, 12'h000));
        wait_idle();
        chk({starts[15:0], 11'h0, sel}, 32'h0001_000d);
        fr(5'h00, 16'h0000);
        chk_rx(st(1'b0, 5'h0d, 12'h5a5));
        res = 12'h0f0;
        fr(5'h10, 16'h005c);
        fr(5'h11, 16'h0403, 24);
        wait_idle();
        fr(5'h11, 16'h0401);
        chk_rx(st(1'b0, 5'h03, 12'h0f0));
        fault_n = 1'b0;
        wdt = 1'b1;
        wait_idle();
        fr(5'h00, 16'h0000);
        chk_rx(st(1'b0, 5'h01, 12'h000));
        $display("conv done");
    endtask : t_conv
    // two-stage reads, second frame a new select
    task automatic t_read();
        fr(5'h13, 16'h0011);
        fr(5'h13, 16'h0013);
        chk_rx({2'h2, ~fault_n, 5'h11, 16'h0401});
        fr(5'h00, 16'h0000);
        chk_rx({2'h2, ~fault_n, 5'h13, 16'h0013});
        $display("read done");
    endtask : t_read
    initial begin
        rstn = 1'b0;
        fault_n = 1'b1;
        wdt = 1'b0;
        res = 12'h000;
        err_count = 0;
        checked = 0;
        starts = 0;
        repeat (16) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (8) @(posedge ref_clk);
        t_reject();
        t_conv();
        t_read();
        final_report();
    end
endmodule : testbench
